// [verilog/iesq_pkg.sv]
package iesq_pkg;
  localparam int NSRC = 8;
  localparam int NSPC = 6;
  // apb map, byte addresses
  localparam logic [7:0] REG_FLAG = 8'h00;
  localparam logic [7:0] REG_ISP = 8'h04;
  localparam logic [7:0] REG_USP = 8'h08;
  localparam logic [7:0] REG_INTB = 8'h0c;
  localparam logic [7:0] REG_CFG = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_SRC0 = 8'h40;
  // processor_flag_word layout
  localparam int FB_D = 1;
  localparam int FB_I = 6;
  localparam int FB_U = 7;
  localparam int FB_IPL = 12;
  localparam logic [15:0] FLG_RST = 16'h0000;
  localparam logic [15:0] FLG_WMASK = 16'h70ff;
  localparam logic [2:0] IPL_MAX = 3'h7;
  // source register fields
  localparam int SRC_RQ = 3;
  // fixed addresses and numbers
  localparam logic [19:0] ACK_ADDR = 20'h00000;
  localparam logic [19:0] FIX_VEC_BASE = 20'hfffdc;
  localparam logic [5:0] MASK_NUM_BASE = 6'h08;
  localparam logic [5:0] TRAP_USP_LO = 6'h20;
  // entry timing in cycles, no waits
  localparam logic [4:0] T_BASE16 = 5'h12;
  localparam logic [4:0] T_BUS8 = 5'h14;
  localparam logic [4:0] T_DBC_EXTRA = 5'h02;
  localparam logic [4:0] T_ONE_EXTRA = 5'h01;
  localparam int WAIT_MAX = 30;
  // special sources, index 0 wins
  localparam int SP_DBC = 0;
  localparam int SP_WDT = 1;
  localparam int SP_OSC = 2;
  localparam int SP_NMI = 3;
  localparam int SP_STEP = 4;
  localparam int SP_AMATCH = 5;

  typedef enum logic [1:0] {K_MASK, K_SPEC, K_TRAP} iesq_kind_t;

  typedef enum {
    ST_IDLE, ST_ACK, ST_FLAG, ST_PUSH, ST_IPL, ST_VLO, ST_VHI, ST_VC1, ST_VC2,
    ST_PAD, ST_JUMP, ST_RLO, ST_RHI, ST_RC1, ST_RC2
  } iesq_state_t;

  typedef struct packed {
    logic valid;
    iesq_kind_t kind;
    logic [2:0] idx;
    logic [2:0] level;
  } iesq_win_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic wide;
    logic [19:0] addr;
    logic [15:0] wdata;
  } iesq_mem_t;
endpackage : iesq_pkg

// [verilog/iesq_top.sv]
// Operation
// RULE_01 - request during an instruction is judged at its end; entry starts next cycle
// RULE_02 - string moves, string store, repeat multiply-accumulate are suspended for entry
// RULE_03 - entry reads the acknowledge address, then clears the source request flag
// RULE_04 - flag word is copied to a hidden holding register before any flag changes
// RULE_05 - entry clears global enable, single-step enable and stack-select flags
// RULE_06 - traps 32 to 63 leave stack-select unchanged, clear the other two
// RULE_07 - push held flags, push program counter, set priority level, load vector
// RULE_08 - vector start address goes to the program counter; routine runs from there
// RULE_09 - wait for instruction end never exceeds thirty cycles
// RULE_10 - entry lasts 18/19/20 cycles by parity on 16-bit bus, 20 on 8-bit
// RULE_11 - debugger break adds two cycles; address match and single step add one
// RULE_12 - accepted maskable request writes its programmed level into priority level
// RULE_13 - oscillation stop, watchdog, pin NMI set level 7; others leave it
// RULE_14 - first item: upper pc nibble, upper flag nibble, low flag byte; then pc low
// RULE_15 - even stack pointer writes words; odd writes each item as two bytes
// RULE_16 - interrupt stack pointer saves, except traps 32-63 use selected pointer
// RULE_17 - return instruction restores flag word and program counter exactly
// RULE_18 - among pending requests only the highest priority is accepted
// RULE_19 - equal maskable levels are ranked by fixed source order
// RULE_20 - special sources have fixed hardware priority
// RULE_21 - software traps bypass arbitration and masking, always taken
// RULE_22 - maskable accepted only with enable set, flag set, level above priority
// RULE_23 - level field 0 disables a source; 1 lowest to 7 highest
// RULE_24 - software clears request flag by writing zero; hardware sets it
// RULE_25 - each stack write pre-decrements the pointer by its byte count
// RULE_26 - arbitration result is registered ahead of the instruction end
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module iesq_top
  import iesq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NSRC-1:0] src_req,
  input wire logic [NSPC-1:0] spc_req,
  input wire logic instr_done,
  input wire logic instr_suspendable,
  input wire logic trap_req,
  input wire logic [5:0] trap_num,
  input wire logic reti_req,
  input wire logic [19:0] cur_pc,
  output logic seq_busy,
  output logic instr_suspend,
  output logic pc_load,
  output logic [19:0] pc_new,
  output iesq_mem_t mem_req,
  input wire logic [15:0] mem_rdata
);
  iesq_state_t state_q;
  iesq_win_t win_d, win_q;
  iesq_kind_t kind_q;
  logic [2:0] idx_q, lvl_q;
  logic [5:0] num_q;
  logic [15:0] flg_q, hold_q, vlo_q;
  logic [19:0] isp_q, usp_q, intb_q, spw_q, pc_q, vaddr_q;
  logic bus8_q, sodd_q, usp_sel_q;
  logic [1:0] ps_q;
  logic [4:0] cnt_q, tgt;
  logic [NSRC-1:0] rq_q;
  logic [2:0] lvl_src [NSRC];
  logic [NSPC-1:0] spc_q;
  logic apb_wr, apb_rd, accept, acked, src_hit;
  logic [2:0] src_sel;
  logic push_last;
  iesq_mem_t mem_d;
  logic [31:0] rdata_d;

  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign src_hit = (paddr >= REG_SRC0) && (paddr < REG_SRC0 + 8'(4 * NSRC));
  assign src_sel = 3'((paddr - REG_SRC0) >> 2);
  assign acked = (state_q == ST_ACK) && (kind_q == K_MASK);

  // per-source request flag and programmed level
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rq_q[g] <= 1'b0;
        lvl_src[g] <= 3'h0;
      end else begin
        if (apb_wr && src_hit && src_sel == 3'(g)) begin
          lvl_src[g] <= pwdata[2:0];
        end
        if (src_req[g]) begin
          rq_q[g] <= 1'b1; // RULE_24
        end else if (acked && idx_q == 3'(g)) begin
          rq_q[g] <= 1'b0; // RULE_03
        end else if (apb_wr && src_hit && src_sel == 3'(g) && !pwdata[SRC_RQ]) begin
          rq_q[g] <= 1'b0; // RULE_24
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spc_q <= '0;
    end else begin
      for (int i = 0; i < NSPC; i++) begin
        if (spc_req[i]) begin
          spc_q[i] <= 1'b1;
        end else if (state_q == ST_ACK && kind_q == K_SPEC && idx_q == 3'(i)) begin
          spc_q[i] <= 1'b0;
        end
      end
    end
  end

  // arbitration: specials beat maskables; loops run low to high rank so last hit wins
  always_comb begin
    win_d = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (flg_q[FB_I] && rq_q[i] && lvl_src[i] != 3'h0 && // RULE_22 RULE_23
          lvl_src[i] > flg_q[FB_IPL +: 3] &&
          (!win_d.valid || lvl_src[i] >= win_d.level)) begin // RULE_19
        win_d = '{valid: 1'b1, kind: K_MASK, idx: 3'(i), level: lvl_src[i]};
      end
    end
    for (int i = NSPC - 1; i >= 0; i--) begin
      if (spc_q[i]) begin
        win_d = '{valid: 1'b1, kind: K_SPEC, idx: 3'(i), level: 3'h0}; // RULE_18 RULE_20
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_q <= '0;
    end else begin
      win_q <= win_d; // RULE_26
    end
  end

  // traps need no winner; string ops are cut short rather than run to completion
  assign instr_suspend = (state_q == ST_IDLE) && !trap_req && win_q.valid &&
                         instr_suspendable && !instr_done; // RULE_02
  assign accept = (state_q == ST_IDLE) && (trap_req || // RULE_21
                  (win_q.valid && (instr_done || instr_suspendable))); // RULE_01
  assign seq_busy = (state_q != ST_IDLE);
  assign push_last = sodd_q ? (ps_q == 2'h3) : (ps_q == 2'h1);

  always_comb begin
    tgt = bus8_q ? T_BUS8 : T_BASE16 + 5'(vaddr_q[0]) + 5'(sodd_q); // RULE_10
    if (kind_q == K_SPEC && idx_q == 3'(SP_DBC)) begin
      tgt = tgt + T_DBC_EXTRA; // RULE_11
    end else if (kind_q == K_SPEC && (idx_q == 3'(SP_STEP) || idx_q == 3'(SP_AMATCH))) begin
      tgt = tgt + T_ONE_EXTRA; // RULE_11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_ACK;
          end else if (reti_req) begin
            state_q <= ST_RLO;
          end
        end
        ST_ACK: state_q <= ST_FLAG;
        ST_FLAG: state_q <= ST_PUSH;
        ST_PUSH: state_q <= push_last ? ST_IPL : ST_PUSH; // RULE_07
        ST_IPL: state_q <= ST_VLO;
        ST_VLO: state_q <= ST_VHI;
        ST_VHI: state_q <= ST_VC1;
        ST_VC1: state_q <= ST_VC2;
        ST_VC2: state_q <= ST_PAD;
        ST_PAD: state_q <= (cnt_q == tgt - 5'h2) ? ST_JUMP : ST_PAD; // RULE_10
        ST_JUMP: state_q <= ST_IDLE;
        ST_RLO: state_q <= ST_RHI;
        ST_RHI: state_q <= ST_RC1;
        ST_RC1: state_q <= ST_RC2;
        ST_RC2: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h0;
    end else begin
      cnt_q <= (state_q == ST_IDLE) ? 5'h0 : cnt_q + 5'h1;
    end
  end

  // capture of what was accepted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_q <= K_MASK;
      idx_q <= 3'h0;
      lvl_q <= 3'h0;
      num_q <= 6'h0;
      pc_q <= 20'h0;
    end else if (accept) begin
      kind_q <= trap_req ? K_TRAP : win_q.kind;
      idx_q <= win_q.idx;
      lvl_q <= win_q.level;
      num_q <= trap_req ? trap_num : MASK_NUM_BASE + 6'(win_q.idx);
      pc_q <= cur_pc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= FLG_RST;
      vaddr_q <= 20'h0;
    end else if (state_q == ST_ACK) begin
      hold_q <= flg_q; // RULE_04
      vaddr_q <= (kind_q == K_SPEC) ? FIX_VEC_BASE + 20'({idx_q, 2'b00})
                                    : intb_q + 20'({num_q, 2'b00});
    end
  end

  // processor_flag_word: hardware updates take precedence over software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flg_q <= FLG_RST;
    end else if (state_q == ST_FLAG) begin
      flg_q[FB_I] <= 1'b0; // RULE_05
      flg_q[FB_D] <= 1'b0; // RULE_05
      if (!(kind_q == K_TRAP && num_q >= TRAP_USP_LO)) begin
        flg_q[FB_U] <= 1'b0; // RULE_06
      end
    end else if (state_q == ST_IPL) begin
      if (kind_q == K_MASK) begin
        flg_q[FB_IPL +: 3] <= lvl_q; // RULE_12
      end else if (kind_q == K_SPEC &&
                   (idx_q == 3'(SP_WDT) || idx_q == 3'(SP_OSC) || idx_q == 3'(SP_NMI))) begin
        flg_q[FB_IPL +: 3] <= IPL_MAX; // RULE_13
      end
    end else if (state_q == ST_RC2) begin
      // the upper item stands on the read bus in this cycle; bits 10:8 carry the old level
      flg_q <= {1'b0, mem_rdata[10:8], 4'h0, mem_rdata[7:0]}; // RULE_17
    end else if (apb_wr && paddr == REG_FLAG) begin
      flg_q <= pwdata[15:0] & FLG_WMASK;
    end
  end

  // stack pointer selection and pre-decrement working copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spw_q <= 20'h0;
      sodd_q <= 1'b0;
      usp_sel_q <= 1'b0;
      ps_q <= 2'h0;
    end else if (state_q == ST_FLAG) begin
      usp_sel_q <= (kind_q == K_TRAP) && (num_q >= TRAP_USP_LO) && hold_q[FB_U]; // RULE_16
      spw_q <= ((kind_q == K_TRAP) && (num_q >= TRAP_USP_LO) && hold_q[FB_U]) ? usp_q : isp_q;
      sodd_q <= ((kind_q == K_TRAP) && (num_q >= TRAP_USP_LO) && hold_q[FB_U]) ? usp_q[0]
                                                                              : isp_q[0];
      ps_q <= 2'h0;
    end else if (state_q == ST_PUSH) begin
      spw_q <= spw_q - (sodd_q ? 20'h1 : 20'h2); // RULE_25
      ps_q <= ps_q + 2'h1;
    end else if (state_q == ST_IDLE && reti_req && !accept) begin
      usp_sel_q <= flg_q[FB_U];
      spw_q <= flg_q[FB_U] ? usp_q : isp_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isp_q <= 20'h0;
      usp_q <= 20'h0;
      intb_q <= 20'h0;
      bus8_q <= 1'b0;
    end else begin
      if (state_q == ST_IPL) begin
        if (usp_sel_q) usp_q <= spw_q;
        else isp_q <= spw_q;
      end else if (state_q == ST_RC2) begin
        if (usp_sel_q) usp_q <= spw_q + 20'h4;
        else isp_q <= spw_q + 20'h4;
      end else if (apb_wr && paddr == REG_ISP) begin
        isp_q <= pwdata[19:0];
      end else if (apb_wr && paddr == REG_USP) begin
        usp_q <= pwdata[19:0];
      end
      if (apb_wr && paddr == REG_INTB) intb_q <= pwdata[19:0];
      if (apb_wr && paddr == REG_CFG) bus8_q <= pwdata[0];
    end
  end

  // stack and vector bus requests
  always_comb begin
    logic [15:0] item1, itm;
    item1 = {pc_q[19:16], hold_q[15:12], hold_q[7:0]}; // RULE_14
    itm = (sodd_q ? !ps_q[1] : (ps_q == 2'h0)) ? item1 : pc_q[15:0]; // RULE_14
    mem_d = '0;
    case (state_q)
      ST_ACK: mem_d = '{valid: 1'b1, wr: 1'b0, wide: 1'b1, addr: ACK_ADDR, wdata: 16'h0}; // RULE_03
      ST_PUSH: begin
        if (sodd_q) begin
          mem_d = '{valid: 1'b1, wr: 1'b1, wide: 1'b0, addr: spw_q - 20'h1, // RULE_15
                    wdata: {8'h0, ps_q[0] ? itm[7:0] : itm[15:8]}};
        end else begin
          mem_d = '{valid: 1'b1, wr: 1'b1, wide: 1'b1, addr: spw_q - 20'h2, wdata: itm};
        end
      end
      ST_VLO: mem_d = '{valid: 1'b1, wr: 1'b0, wide: 1'b1, addr: vaddr_q, wdata: 16'h0};
      ST_VHI: mem_d = '{valid: 1'b1, wr: 1'b0, wide: 1'b1, addr: vaddr_q + 20'h2, wdata: 16'h0};
      ST_RLO: mem_d = '{valid: 1'b1, wr: 1'b0, wide: 1'b1, addr: spw_q, wdata: 16'h0};
      ST_RHI: mem_d = '{valid: 1'b1, wr: 1'b0, wide: 1'b1, addr: spw_q + 20'h2, wdata: 16'h0};
      default: mem_d = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req <= '0;
    end else begin
      mem_req <= mem_d;
    end
  end

  // read data returns two cycles after the request is decided
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vlo_q <= 16'h0;
    end else if (state_q == ST_VC1 || state_q == ST_RC1) begin
      vlo_q <= mem_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_load <= 1'b0;
      pc_new <= 20'h0;
    end else begin
      pc_load <= 1'b0;
      if (state_q == ST_VC2) begin
        pc_new <= {mem_rdata[3:0], vlo_q}; // RULE_08
      end else if (state_q == ST_JUMP) begin
        pc_load <= 1'b1; // RULE_07 RULE_08
      end else if (state_q == ST_RC2) begin
        pc_new <= {mem_rdata[15:12], vlo_q}; // RULE_17
        pc_load <= 1'b1;
      end
    end
  end

  // apb read path; data registered in the setup phase
  always_comb begin
    rdata_d = 32'h0;
    case (paddr)
      REG_FLAG: rdata_d = {16'h0, flg_q};
      REG_ISP: rdata_d = {12'h0, isp_q};
      REG_USP: rdata_d = {12'h0, usp_q};
      REG_INTB: rdata_d = {12'h0, intb_q};
      REG_CFG: rdata_d = {31'h0, bus8_q};
      REG_STAT: rdata_d = {16'h0, 2'h0, num_q, 3'h0, win_q.valid, 3'h0, seq_busy};
      default: begin
        if (src_hit) rdata_d = {28'h0, rq_q[src_sel], lvl_src[src_sel]};
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= apb_rd ? rdata_d : 32'h0;
      pslverr <= !(src_hit || paddr == REG_FLAG || paddr == REG_ISP || paddr == REG_USP ||
                   paddr == REG_INTB || paddr == REG_CFG || paddr == REG_STAT);
    end
  end

  // helper for the wait bound
  logic [5:0] wait_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wait_q <= 6'h0;
    else if (state_q == ST_IDLE && win_q.valid && !accept) wait_q <= wait_q + 6'h1;
    else wait_q <= 6'h0;
  end

  a_wait_bound: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    wait_q <= 6'(WAIT_MAX)) else $error("instruction end wait too long");
  a_start_next: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    accept |=> state_q == ST_ACK) else $error("entry did not start next cycle");
  a_ack_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    state_q == ST_ACK |=> mem_req.valid && !mem_req.wr && mem_req.addr == ACK_ADDR)
    else $error("acknowledge read missing");
  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    acked && !src_req[idx_q] |=> !rq_q[$past(idx_q)]) else $error("request flag not cleared");
  a_hold_copy: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    state_q == ST_ACK |=> hold_q == $past(flg_q)) else $error("flag word not held");
  a_flags_cleared: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    state_q == ST_FLAG |=> !flg_q[FB_I] && !flg_q[FB_D] &&
    (flg_q[FB_U] == ($past(flg_q[FB_U]) && kind_q == K_TRAP && num_q >= TRAP_USP_LO)))
    else $error("entry flags wrong");
  a_push_order: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    state_q == ST_FLAG ##1 !sodd_q |=> mem_req.wr && mem_req.wdata[15:12] == pc_q[19:16]
    ##1 mem_req.wr && mem_req.wdata == pc_q[15:0]) else $error("push order wrong");
  a_odd_bytes: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
    state_q == ST_PUSH && sodd_q |=> mem_req.valid && !mem_req.wide)
    else $error("odd stack not written bytewise");
  a_ipl_special: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
    state_q == ST_IPL && kind_q == K_SPEC && idx_q == 3'(SP_NMI) |=> flg_q[FB_IPL +: 3] == 3'h7)
    else $error("nmi did not raise level");
  a_entry_len: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
    state_q == ST_JUMP && !bus8_q && kind_q == K_MASK && !vaddr_q[0] && !sodd_q
    |-> cnt_q == 5'd17) else $error("entry length not 18");
  a_mask_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
    win_d.valid && win_d.kind == K_MASK |-> flg_q[FB_I] && win_d.level > flg_q[FB_IPL +: 3])
    else $error("maskable winner not enabled");
endmodule : iesq_top
`default_nettype wire

// [verif/iesq_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
module iesq_mem_model
  import iesq_pkg::*;
(
  input wire logic pclk,
  input wire iesq_mem_t mem_req,
  output logic [15:0] mem_rdata
);
  logic [7:0] m [logic [19:0]];
  logic [19:0] wlog [$];
  int ack_cnt = 0;
  initial mem_rdata = 16'h0000;
  // bytes never written read as an address pattern, so stale data cannot pass
  function automatic logic [15:0] rd16(input logic [19:0] a);
    return {m.exists(a + 20'h1) ? m[a + 20'h1] : ~a[7:0], m.exists(a) ? m[a] : a[7:0]};
  endfunction : rd16
  task automatic poke(input logic [19:0] a, input logic [15:0] d);
    m[a] = d[7:0];
    m[a + 20'h1] = d[15:8];
  endtask : poke
  // read data lands one cycle after the request; otherwise it toggles every cycle
  always @(posedge pclk) begin
    mem_rdata <= ~mem_rdata;
    if (mem_req.valid === 1'b1 && mem_req.wr === 1'b1) begin
      wlog.push_back(mem_req.addr);
      m[mem_req.addr] = mem_req.wdata[7:0];
      if (mem_req.wide === 1'b1)
        m[mem_req.addr + 20'h1] = mem_req.wdata[15:8];
    end else if (mem_req.valid === 1'b1) begin
      ack_cnt += int'(mem_req.addr == ACK_ADDR);
      mem_rdata <= rd16(mem_req.addr);
    end
  end
endmodule : iesq_mem_model
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench
  import iesq_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic instr_done = 1'b0, instr_suspendable = 1'b0, trap_req = 1'b0, reti_req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, se, seq_busy, instr_suspend, pc_load;
  logic [NSRC-1:0] src_req = 8'h00;
  logic [NSPC-1:0] spc_req = 6'h00;
  logic [5:0] trap_num = 6'h00;
  logic [19:0] cur_pc = 20'h00000, pc, pc_new;
  logic [15:0] mem_rdata, processor_flag_word;
  iesq_mem_t mem_req;
  int seed = 32'h51e37abc;
  int err_count = 0;
  int check_count = 0;
  iesq_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .src_req, .spc_req, .instr_done, .instr_suspendable, .trap_req,
    .trap_num, .reti_req, .cur_pc, .seq_busy, .instr_suspend, .pc_load, .pc_new,
    .mem_req, .mem_rdata);
  iesq_mem_model u_mem (.pclk, .mem_req, .mem_rdata);
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (e !== s) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // outputs are looked at on the falling edge, where they have settled
  task automatic quiet(input int n);
    int b = 0;
    repeat (n) begin
      @(negedge pclk);
      b += int'(seq_busy !== 1'b0);
    end
    chk("idle_busy", 0, b);
  endtask : quiet
  task automatic pulse(input logic [7:0] s, input logic [5:0] k);
    @(posedge pclk);
    src_req <= s;
    spc_req <= k;
    @(posedge pclk);
    src_req <= 8'h00;
    spc_req <= 6'h00;
    quiet(6);
  endtask : pulse
  task automatic wait_pc(output int n);
    n = 0;
    for (int k = 0; k < 200; k++) begin
      @(negedge pclk);
      if (pc_load === 1'b1) break;
      n += int'(seq_busy === 1'b1);
    end
  endtask : wait_pc
  task automatic setup(input logic [15:0] f, input logic [19:0] sp, input logic [19:0] vb,
      input logic b8);
    processor_flag_word = f;
    apb(1'b1, REG_FLAG, {16'h0, f});
    apb(1'b1, REG_ISP, {12'h0, sp});
    apb(1'b1, REG_USP, {12'h0, sp ^ 20'h10000});
    apb(1'b1, REG_INTB, {12'h0, vb});
    apb(1'b1, REG_CFG, {31'h0, b8});
  endtask : setup
  task automatic ent(input int how, input logic [19:0] va, input int tgt, input logic [2:0] processor_priority_level,
      input logic [7:0] spa, input int sx);
    logic [19:0] sp0;
    logic [15:0] lo, hi, e;
    int n, acks;
    apb(1'b0, spa, 0);
    sp0 = r[19:0];
    lo = 16'($random(seed));
    hi = 16'($random(seed));
    pc = 20'($random(seed));
    u_mem.poke(va, lo);
    u_mem.poke(va + 20'h2, hi);
    u_mem.wlog.delete();
    acks = u_mem.ack_cnt;
    @(posedge pclk);
    cur_pc <= pc;
    instr_done <= (how == 0);
    trap_req <= (how == 1);
    instr_suspendable <= (how == 2);
    @(negedge pclk);
    chk("suspend", 32'(how == 2), 32'(instr_suspend));
    @(posedge pclk);
    instr_done <= 1'b0;
    trap_req <= 1'b0;
    instr_suspendable <= 1'b0;
    wait_pc(n);
    chk("cycles", tgt, n);
    chk("pc_new", {hi[3:0], lo}, pc_new);
    chk("ack_read", acks + 1, u_mem.ack_cnt);
    chk("first_write", sp0 - (sp0[0] ? 20'h1 : 20'h2), u_mem.wlog[0]);
    chk("item_hi", {pc[19:16], processor_flag_word[15:12], processor_flag_word[7:0]}, u_mem.rd16(sp0 - 20'h2));
    chk("item_lo", pc[15:0], u_mem.rd16(sp0 - 20'h4));
    apb(1'b0, spa, 0);
    chk("sp", sp0 - 20'h4, r[19:0]);
    e = processor_flag_word;
    e[FB_I] = 1'b0;
    e[FB_D] = 1'b0;
    if (spa == REG_ISP) e[FB_U] = 1'b0;
    e[14:12] = processor_priority_level;
    apb(1'b0, REG_FLAG, 0);
    chk("flag", e, r[15:0]);
    if (sx >= 0) begin
      apb(1'b0, REG_SRC0 + 8'(4 * sx), 0);
      chk("req_flag", 0, r[SRC_RQ]);
    end
    // losers stay pending; clear them so the return cannot re-enter at once
    for (int j = 0; j < NSRC; j++) apb(1'b1, REG_SRC0 + 8'(4 * j), 0);
    @(posedge pclk);
    reti_req <= 1'b1;
    @(posedge pclk);
    reti_req <= 1'b0;
    wait_pc(n);
    chk("ret_pc", pc, pc_new);
    apb(1'b0, REG_FLAG, 0);
    chk("ret_flag", processor_flag_word, r[15:0]);
  endtask : ent
  initial begin
    int s, l, p, t;
    logic [19:0] sp, vb;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_FLAG, 0);
    chk("flag_reset", FLG_RST, r[15:0]);
    apb(1'b1, 8'h3c, 32'h1);
    chk("slverr", 1, se);
    for (int i = 0; i < 8; i++) begin
      s = {$random(seed)} % NSRC;
      l = 1 + {$random(seed)} % 7;
      p = {$random(seed)} % l;
      sp = {4'h8, 15'($random(seed)), i[0]};
      vb = {19'h20000, i[1]};
      t = i[2] ? 20 : 18 + i[0] + i[1];
      setup({1'b0, p[2:0], 4'h0, 8'($random(seed)) | 8'h40}, sp, vb, i[2]);
      apb(1'b1, REG_SRC0 + 8'(4 * s), 32'(8 + l));
      apb(1'b0, REG_SRC0 + 8'(4 * s), 0);
      chk("no_set", 0, r[SRC_RQ]);
      pulse(8'(1 << s), 6'h00);
      ent(i == 3 ? 2 : 0, vb + 20'(4 * (8 + s)), t, 3'(l), REG_ISP, s);
    end
    for (int j = 0; j < 2; j++) begin
      setup(16'h0040, 20'h90000, 20'h40000, 1'b0);
      apb(1'b1, REG_SRC0 + 8'(j ? 4 : 8), j ? 2 : 4);
      apb(1'b1, REG_SRC0 + 8'(j ? 24 : 20), j ? 6 : 4);
      pulse(j ? 8'h42 : 8'h24, 6'h00);
      ent(0, 20'h40000 + 20'(4 * (j ? 14 : 10)), 18, j ? 3'h6 : 3'h4, REG_ISP, j ? 6 : 2);
    end
    setup(16'h3000, 20'h90000, 20'h40000, 1'b0);
    apb(1'b1, REG_SRC0 + 8'h0c, 0);
    apb(1'b1, REG_SRC0 + 8'h10, 3);
    pulse(8'h18, 6'h00);
    for (int j = 0; j < 2; j++) begin
      if (j == 1) apb(1'b1, REG_FLAG, 32'h3040);
      @(posedge pclk);
      instr_done <= 1'b1;
      @(posedge pclk);
      instr_done <= 1'b0;
      quiet(6);
    end
    processor_flag_word = 16'h3040;
    apb(1'b1, REG_SRC0 + 8'h10, 32'hc);
    quiet(4);
    ent(0, 20'h40000 + 20'(4 * 12), 18, 3'h4, REG_ISP, 4);
    for (int k = 0; k < NSPC; k++) begin
      setup(16'h2042, 20'h90000, 20'h40000, 1'b0);
      apb(1'b1, REG_SRC0, 7);
      pulse(8'h01, 6'(1 << k));
      t = 18 + (k == SP_DBC ? 2 : int'(k == SP_STEP || k == SP_AMATCH));
      p = (k == SP_WDT || k == SP_OSC || k == SP_NMI) ? 7 : 2;
      ent(0, FIX_VEC_BASE + 20'(4 * k), t, 3'(p), REG_ISP, -1);
    end
    for (int j = 0; j < 2; j++) begin
      setup(16'h5081, 20'h90000, 20'h40000, 1'b0);
      trap_num <= j ? 6'h05 : 6'h28;
      ent(1, 20'h40000 + (j ? 20'h14 : 20'ha0), 18, 3'h5, j ? REG_ISP : REG_USP, -1);
    end
    tally_and_finish;
  end
  // the whole sequence needs well under a tenth of this span
  initial begin
    #(25 * 60000);
    err_count++;
    tally_and_finish;
  end
endmodule : testbench
`default_nettype wire
